// >>> pkg/cpr_defines.svh
// register offsets, field positions, reset values and codes of the caption port router
`ifndef CPR_DEFINES_SVH
`define CPR_DEFINES_SVH

`define CPR_OFF_PORT_OUT    12'h000
`define CPR_OFF_GLOBAL      12'h004
`define CPR_OFF_STATUS      12'h008
`define CPR_OFF_CH_A        12'h010
`define CPR_OFF_CH_B        12'h020
`define CPR_OFF_ROUTE       4'h0
`define CPR_OFF_CC_LINES    4'h4
`define CPR_OFF_GPI_CTRL    4'h8
`define CPR_OFF_GPI_LINES   4'hC

`define CPR_F_SRC_LSB       0
`define CPR_F_LINE_LO_LSB   0
`define CPR_F_LINE_HI_LSB   16
`define CPR_F_GPI_EN        0
`define CPR_F_MODE_LSB      1
`define CPR_F_TX_OR         3
`define CPR_F_POL_LSB       4
`define CPR_F_MAP_LSB       8
`define CPR_F_TMO_LSB       16
`define CPR_F_SPEED_LSB     0
`define CPR_F_XCODE_LSB     4
`define CPR_F_DEC_FMT       8

`define CPR_RST_HD_CC_LINE  11'h009
`define CPR_RST_SD_CC_LINE  11'h015
`define CPR_RST_GPI_LINE    11'h00D
`define CPR_RST_SPEED       4'h7
`define CPR_SPEED_115K2     4'h7
`define CPR_FRAME_BYTE      8'h01

`endif

// >>> pkg/cpr_pkg.sv
// types of the caption port router
package cpr_pkg;

    typedef enum logic [2:0] {
        CPR_SRC_NONE   = 3'b000,
        CPR_SRC_SERIAL = 3'b001,
        CPR_SRC_ETH1   = 3'b010,
        CPR_SRC_ETH2   = 3'b011,
        CPR_SRC_USB    = 3'b100
    } cpr_src_t;

    typedef enum logic [1:0] {
        CPR_OUT_NONE = 2'b00,
        CPR_OUT_CH_A = 2'b01,
        CPR_OUT_CH_B = 2'b10
    } cpr_out_t;

    typedef enum logic [2:0] {
        CPR_XC_NONE   = 3'b000,
        CPR_XC_AB_ALL = 3'b001,
        CPR_XC_AB_F1  = 3'b010,
        CPR_XC_AB_F2  = 3'b011,
        CPR_XC_BA_ALL = 3'b100,
        CPR_XC_BA_F1  = 3'b101,
        CPR_XC_BA_F2  = 3'b110
    } cpr_xcode_t;

    typedef enum logic [1:0] {
        CPR_INS_NORMAL  = 2'b00,
        CPR_INS_PERM_F0 = 2'b01,
        CPR_INS_PERM_F1 = 2'b10,
        CPR_INS_PERM_2F = 2'b11
    } cpr_ins_t;

    typedef struct packed {
        cpr_src_t        src;
        logic [10:0]     hd_cc_line;
        logic [10:0]     sd_cc_line;
        logic            gpi_en;
        cpr_ins_t        ins_mode;
        logic            tx_or;
        logic [3:0]      tx_pol;
        logic [3:0][1:0] tx_map;
        logic [15:0]     timeout;
        logic [10:0]     sd_gpi_line;
        logic [10:0]     hd_gpi_line;
    } cpr_chcfg_t;

endpackage

// >>> rtl/cpr_sync3.sv
// three-stage synchroniser for the contact trigger inputs
`timescale 1ns/1ps
`default_nettype none

module cpr_sync3 (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] async_in,
    output logic      [7:0] sync_out
);

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] q;
    } cpr_sync_t;

    cpr_sync_t st;
    cpr_sync_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // a change counts once stages two and three agree
        for (int i = 0; i < 8; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.q;

endmodule // cpr_sync3

`default_nettype wire

// >>> rtl/cpr_router.sv
// two-channel caption port router and transmission bit builder with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "cpr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - each channel picks its inserter source: serial, eth 1, eth 2, usb or none
// - each output port carries decoded captions of channel a, b or nothing
// - ethernet ports work only at 115.2k; other speeds cut them off
// - serial and usb ports follow any rate in the port speed setting
// - per channel caption line: one for hd, one for sd
// - bytes from a channel's source port are inserted into its output video
// - both channels route, decode and encode independently at once while transcode is off
// - transcode bridges a to b using both fields, field 1 or field 2
// - bridging b to a exists with the same field options
// - after the timeout interval insertion stops and received data passes
// - insert mode: normal, permanent in field 0, field 1 or both
// - transmission bits go on a configurable sd or hd line
// - active low: low input sends 1; active high: low input sends 0
// - each contact input maps to any transmission bit position
// - bits are the mapped input alone or ORed with received bits
module cpr_router (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic [1:0]  ch_frame_start,
    input  wire logic [1:0]  ch_field,
    input  wire logic [1:0]  ch_hd,
    input  wire logic [1:0]  ch_dec_valid,
    input  wire logic [15:0] ch_dec_data,
    input  wire logic [7:0]  ch_rx_gpi,
    input  wire logic [7:0]  contact_trigger_inputs,
    input  wire logic [3:0]  port_rx_valid,
    input  wire logic [31:0] port_rx_data,
    output logic      [3:0]  port_tx_valid,
    output logic      [31:0] port_tx_data,
    output logic      [3:0]  port_speed,
    output logic      [1:0]  ins_valid,
    output logic      [15:0] ins_data,
    output logic      [21:0] ins_line,
    output logic      [1:0]  gpi_ins_valid,
    output logic      [7:0]  gpi_ins_bits,
    output logic      [21:0] gpi_ins_line
);

    typedef struct packed {
        cpr_pkg::cpr_chcfg_t [1:0] shadow;
        cpr_pkg::cpr_chcfg_t [1:0] active;
        logic [1:0]                pend;
        cpr_pkg::cpr_out_t [3:0]   port_out;
        logic [3:0]                speed;
        cpr_pkg::cpr_xcode_t       xcode;
        logic                      dec_fmt;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
        logic [1:0][15:0]          tmo_cnt;
        logic [1:0][3:0]           last_trig;
        logic [1:0]                hdr_pend;
        logic [1:0]                hold_valid;
        logic [1:0][7:0]           hold_data;
        logic [1:0]                ins_valid;
        logic [1:0][7:0]           ins_data;
        logic [1:0][10:0]          ins_line;
        logic [1:0]                gpi_valid;
        logic [1:0][3:0]           gpi_bits;
        logic [1:0][10:0]          gpi_line;
        logic [3:0]                tx_valid;
        logic [3:0][7:0]           tx_data;
    } cpr_state_t;

    cpr_state_t st;
    cpr_state_t next_st;
    logic [7:0] trig_sync;

    ////////////////////////////////////////////////////////////////////////////
    // contact input synchroniser

    cpr_sync3 u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (contact_trigger_inputs),
        .sync_out (trig_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic cpr_pkg::cpr_chcfg_t cfg_reset();
        cpr_pkg::cpr_chcfg_t c;
        c             = '0;
        c.hd_cc_line  = `CPR_RST_HD_CC_LINE;
        c.sd_cc_line  = `CPR_RST_SD_CC_LINE;
        c.sd_gpi_line = `CPR_RST_GPI_LINE;
        c.hd_gpi_line = `CPR_RST_GPI_LINE;
        return c;
    endfunction

    function automatic logic [31:0] cfg_read(input cpr_pkg::cpr_chcfg_t c, input logic [3:0] off);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (off == `CPR_OFF_ROUTE) begin
            r[`CPR_F_SRC_LSB +: 3] = c.src;
        end else if (off == `CPR_OFF_CC_LINES) begin
            r[`CPR_F_LINE_LO_LSB +: 11] = c.hd_cc_line;
            r[`CPR_F_LINE_HI_LSB +: 11] = c.sd_cc_line;
        end else if (off == `CPR_OFF_GPI_CTRL) begin
            r[`CPR_F_GPI_EN]         = c.gpi_en;
            r[`CPR_F_MODE_LSB +: 2]  = c.ins_mode;
            r[`CPR_F_TX_OR]          = c.tx_or;
            r[`CPR_F_POL_LSB +: 4]   = c.tx_pol;
            r[`CPR_F_MAP_LSB +: 8]   = c.tx_map;
            r[`CPR_F_TMO_LSB +: 16]  = c.timeout;
        end else begin
            r[`CPR_F_LINE_LO_LSB +: 11] = c.sd_gpi_line;
            r[`CPR_F_LINE_HI_LSB +: 11] = c.hd_gpi_line;
        end
        return r;
    endfunction

    function automatic cpr_pkg::cpr_chcfg_t cfg_write(input cpr_pkg::cpr_chcfg_t c, input logic [3:0] off,
                                                      input logic [31:0] d);
        cpr_pkg::cpr_chcfg_t n;
        n = c;
        if (off == `CPR_OFF_ROUTE) begin
            n.src = cpr_pkg::cpr_src_t'(d[`CPR_F_SRC_LSB +: 3]);
        end else if (off == `CPR_OFF_CC_LINES) begin
            n.hd_cc_line = d[`CPR_F_LINE_LO_LSB +: 11];
            n.sd_cc_line = d[`CPR_F_LINE_HI_LSB +: 11];
        end else if (off == `CPR_OFF_GPI_CTRL) begin
            n.gpi_en   = d[`CPR_F_GPI_EN];
            n.ins_mode = cpr_pkg::cpr_ins_t'(d[`CPR_F_MODE_LSB +: 2]);
            n.tx_or    = d[`CPR_F_TX_OR];
            n.tx_pol   = d[`CPR_F_POL_LSB +: 4];
            n.tx_map   = d[`CPR_F_MAP_LSB +: 8];
            n.timeout  = d[`CPR_F_TMO_LSB +: 16];
        end else begin
            n.sd_gpi_line = d[`CPR_F_LINE_LO_LSB +: 11];
            n.hd_gpi_line = d[`CPR_F_LINE_HI_LSB +: 11];
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic        eth_ok;
        logic        bridging;
        logic        src_ch;
        logic        dst_ch;
        logic        src_field_ok;
        logic [1:0]  emit_valid;
        logic [1:0][7:0] emit_data;
        logic [1:0]  port_idx;
        logic        expired;
        logic        perm_match;
        logic        lvl;
        logic [3:0]  bits;
        logic        ch;
        logic [11:0] base;
        logic        in_ch_a;
        logic        in_ch_b;
        logic        apb_setup;
        logic        apb_wr;
        eth_ok       = 1'b0;
        bridging     = 1'b0;
        src_ch       = 1'b0;
        dst_ch       = 1'b0;
        src_field_ok = 1'b0;
        emit_valid   = 2'b00;
        emit_data    = '0;
        port_idx     = 2'b00;
        expired      = 1'b0;
        perm_match   = 1'b0;
        lvl          = 1'b0;
        bits         = 4'h0;
        ch           = 1'b0;
        base         = 12'h000;
        in_ch_a      = 1'b0;
        in_ch_b      = 1'b0;
        apb_setup    = 1'b0;
        apb_wr       = 1'b0;
        next_st      = st;

        eth_ok = (st.speed == `CPR_SPEED_115K2);
        bridging = (st.xcode != cpr_pkg::CPR_XC_NONE);
        src_ch = (st.xcode >= cpr_pkg::CPR_XC_BA_ALL);
        dst_ch = !src_ch;
        // field 1 is the odd field, field input low
        if (st.xcode == cpr_pkg::CPR_XC_AB_F1 || st.xcode == cpr_pkg::CPR_XC_BA_F1) begin
            src_field_ok = !ch_field[src_ch];
        end else if (st.xcode == cpr_pkg::CPR_XC_AB_F2 || st.xcode == cpr_pkg::CPR_XC_BA_F2) begin
            src_field_ok = ch_field[src_ch];
        end else begin
            src_field_ok = 1'b1;
        end

        for (int c = 0; c < 2; c++) begin
            // settings take effect together at the frame boundary
            if (ch_frame_start[c] && st.pend[c]) begin
                next_st.active[c] = st.shadow[c];
                next_st.pend[c]   = 1'b0;
            end

            // decoded stream with optional frame header byte
            next_st.hold_valid[c] = 1'b0;
            if (st.hold_valid[c]) begin
                emit_valid[c] = 1'b1;
                emit_data[c]  = st.hold_data[c];
            end else if (ch_dec_valid[c]) begin
                emit_valid[c] = 1'b1;
                if (!st.dec_fmt && st.hdr_pend[c]) begin
                    emit_data[c]          = `CPR_FRAME_BYTE;
                    next_st.hold_valid[c] = 1'b1;
                    next_st.hold_data[c]  = ch_dec_data[c*8 +: 8];
                    next_st.hdr_pend[c]   = 1'b0;
                end else begin
                    emit_data[c] = ch_dec_data[c*8 +: 8];
                end
            end
            if (ch_frame_start[c]) begin
                next_st.hdr_pend[c] = 1'b1;
            end

            // caption insertion
            next_st.ins_valid[c] = 1'b0;
            next_st.ins_data[c]  = st.ins_data[c];
            if (bridging) begin
                if (c[0] == dst_ch) begin
                    next_st.ins_valid[c] = ch_dec_valid[src_ch] && src_field_ok;
                    next_st.ins_data[c]  = ch_dec_data[src_ch*8 +: 8];
                end
            end else if (st.active[c].src != cpr_pkg::CPR_SRC_NONE) begin
                port_idx = 2'(st.active[c].src - cpr_pkg::CPR_SRC_SERIAL);
                if (port_idx == 2'd0 || port_idx == 2'd3 || eth_ok) begin
                    next_st.ins_valid[c] = port_rx_valid[port_idx];
                    next_st.ins_data[c]  = port_rx_data[port_idx*8 +: 8];
                end
            end
            next_st.ins_line[c] = ch_hd[c] ? st.active[c].hd_cc_line : st.active[c].sd_cc_line;

            // transmission bits
            bits = 4'h0;
            for (int i = 0; i < 4; i++) begin
                lvl = st.active[c].tx_pol[i] ? !trig_sync[c*4+i] : trig_sync[c*4+i];
                bits[st.active[c].tx_map[i]] = bits[st.active[c].tx_map[i]] | lvl;
            end
            if (st.active[c].tx_or) begin
                bits = bits | ch_rx_gpi[c*4 +: 4];
            end
            next_st.gpi_bits[c] = bits;
            next_st.gpi_line[c] = ch_hd[c] ? st.active[c].hd_gpi_line : st.active[c].sd_gpi_line;

            // timeout counts frames without a change at the contacts
            next_st.last_trig[c] = trig_sync[c*4 +: 4];
            expired = (st.active[c].timeout != 16'h0000) && (st.tmo_cnt[c] >= st.active[c].timeout);
            if (trig_sync[c*4 +: 4] != st.last_trig[c]) begin
                next_st.tmo_cnt[c] = 16'h0000;
            end else if (ch_frame_start[c] && !expired) begin
                next_st.tmo_cnt[c] = 16'(st.tmo_cnt[c] + 16'h0001);
            end
            case (st.active[c].ins_mode)
                cpr_pkg::CPR_INS_PERM_F0: perm_match = !ch_field[c];
                cpr_pkg::CPR_INS_PERM_F1: perm_match = ch_field[c];
                cpr_pkg::CPR_INS_PERM_2F: perm_match = 1'b1;
                default:                  perm_match = 1'b0;
            endcase
            next_st.gpi_valid[c] = st.active[c].gpi_en && (perm_match || !expired);
        end

        // decoded captions to output ports
        for (int p = 0; p < 4; p++) begin
            ch = (st.port_out[p] == cpr_pkg::CPR_OUT_CH_B);
            next_st.tx_valid[p] = 1'b0;
            next_st.tx_data[p]  = st.tx_data[p];
            if (!bridging && st.port_out[p] != cpr_pkg::CPR_OUT_NONE && (p == 0 || p == 3 || eth_ok)) begin
                next_st.tx_valid[p] = emit_valid[ch];
                next_st.tx_data[p]  = emit_data[ch];
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // apb slave, no wait state, answers in the access phase
        apb_setup = psel && !penable && !st.pready;
        apb_wr    = psel && penable && st.pready && pwrite;
        in_ch_a   = (paddr[11:4] == `CPR_OFF_CH_A >> 4) && (paddr[1:0] == 2'b00);
        in_ch_b   = (paddr[11:4] == `CPR_OFF_CH_B >> 4) && (paddr[1:0] == 2'b00);
        base      = in_ch_b ? `CPR_OFF_CH_B : `CPR_OFF_CH_A;
        next_st.pready = apb_setup;
        if (apb_setup) begin
            next_st.pslverr = 1'b0;
            next_st.prdata  = 32'h0000_0000;
            if (paddr == `CPR_OFF_PORT_OUT) begin
                next_st.prdata[7:0] = st.port_out;
            end else if (paddr == `CPR_OFF_GLOBAL) begin
                next_st.prdata[`CPR_F_SPEED_LSB +: 4] = st.speed;
                next_st.prdata[`CPR_F_XCODE_LSB +: 3] = st.xcode;
                next_st.prdata[`CPR_F_DEC_FMT]        = st.dec_fmt;
            end else if (paddr == `CPR_OFF_STATUS) begin
                next_st.prdata[0]   = eth_ok;
                next_st.prdata[2:1] = {st.active[1].gpi_en && !st.gpi_valid[1],
                                       st.active[0].gpi_en && !st.gpi_valid[0]};
                next_st.prdata[3]   = bridging;
                next_st.prdata[5:4] = st.pend;
            end else if (in_ch_a || in_ch_b) begin
                next_st.prdata = cfg_read(st.shadow[in_ch_b], paddr[3:0] - base[3:0]);
            end else begin
                next_st.pslverr = 1'b1;
            end
        end else if (psel && penable && st.pready) begin
            next_st.pslverr = 1'b0;
        end
        if (apb_wr && !st.pslverr) begin
            if (paddr == `CPR_OFF_PORT_OUT) begin
                for (int p = 0; p < 4; p++) begin
                    next_st.port_out[p] = cpr_pkg::cpr_out_t'(pwdata[2*p +: 2]);
                end
            end else if (paddr == `CPR_OFF_GLOBAL) begin
                next_st.speed   = pwdata[`CPR_F_SPEED_LSB +: 4];
                next_st.xcode   = cpr_pkg::cpr_xcode_t'(pwdata[`CPR_F_XCODE_LSB +: 3]);
                next_st.dec_fmt = pwdata[`CPR_F_DEC_FMT];
            end else if (in_ch_a || in_ch_b) begin
                next_st.shadow[in_ch_b] = cfg_write(st.shadow[in_ch_b], paddr[3:0], pwdata);
                next_st.pend[in_ch_b]   = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= '0;
            st.shadow[0] <= cfg_reset();
            st.shadow[1] <= cfg_reset();
            st.active[0] <= cfg_reset();
            st.active[1] <= cfg_reset();
            st.speed     <= `CPR_RST_SPEED;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign pready        = st.pready;
    assign prdata        = st.prdata;
    assign pslverr       = st.pslverr;
    assign port_tx_valid = st.tx_valid;
    assign port_tx_data  = st.tx_data;
    assign port_speed    = st.speed;
    assign ins_valid     = st.ins_valid;
    assign ins_data      = st.ins_data;
    assign ins_line      = st.ins_line;
    assign gpi_ins_valid = st.gpi_valid;
    assign gpi_ins_bits  = st.gpi_bits;
    assign gpi_ins_line  = st.gpi_line;

endmodule // cpr_router

`default_nettype wire

// >>> sim/cpr_router_checker.sv
// port assertions of the caption port router
`timescale 1ns/1ps
`default_nettype none
module cpr_router_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [1:0]  ch_dec_valid,
    input wire logic [3:0]  port_rx_valid,
    input wire logic [3:0]  port_tx_valid,
    input wire logic [3:0]  port_speed,
    input wire logic [1:0]  ins_valid
);
    logic xc_on;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) xc_on <= 1'b0;
        else if (psel && penable && pwrite && paddr == 12'h004) xc_on <= pwdata[6:4] != 3'h0;
    end
    AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer late or long");
    AST_READY_ACCESS: assert property (pready |-> psel && penable && !$past(penable))
        else $error("pready outside access");
    AST_ERR_READ_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access not clean");
    AST_SPEED_FOLLOWS: assert property (psel && penable && pready && pwrite && paddr == 12'h004
        |-> ##2 port_speed == $past(pwdata[3:0], 2)) else $error("speed not taken");
    AST_ETH_GATE: assert property (port_tx_valid[2:1] != 2'b00
        |-> $past(port_speed) == 4'h7 || $past(port_speed, 2) == 4'h7) else $error("eth tx off speed");
    AST_INS_CAUSE: assert property (ins_valid != 2'b00
        |-> $past(port_rx_valid) != 4'h0 || $past(ch_dec_valid) != 2'b00) else $error("insert without byte");
    AST_TX_CAUSE: assert property (port_tx_valid != 4'h0
        |-> $past(ch_dec_valid) != 2'b00 || $past(ch_dec_valid, 2) != 2'b00) else $error("tx without byte");
    AST_BRIDGE_QUIET: assert property (xc_on && $past(xc_on) && $past(xc_on, 2) |-> port_tx_valid == 4'h0)
        else $error("port tx while bridging");
endmodule // cpr_router_checker
bind cpr_router cpr_router_checker i_chk (.*);
`default_nettype wire

// >>> sim/cpr_port_model.sv
// caption source and sink on the four ports
`timescale 1ns/1ps
`default_nettype none
module cpr_port_model (
    input  wire logic        pclk,
    input  wire logic [3:0]  port_tx_valid,
    input  wire logic [31:0] port_tx_data,
    output logic      [3:0]  port_rx_valid,
    output logic      [31:0] port_rx_data
);
    logic [7:0] got_q[4][$];
    initial {port_rx_valid, port_rx_data} = '0;
    task automatic send(input int p, input logic [7:0] b);
        port_rx_valid[p] <= 1'b1;
        port_rx_data[8*p+:8] <= b;
        @(posedge pclk);
        port_rx_valid[p] <= 1'b0;
        port_rx_data[8*p+:8] <= ~b;
    endtask
    always @(posedge pclk)
        for (int p = 0; p < 4; p++)
            if (port_tx_valid[p] === 1'b1) got_q[p].push_back(port_tx_data[8*p+:8]);
endmodule // cpr_port_model
`default_nettype wire

// >>> sim/tb_top.sv
// testbench of the caption port router
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, port_rx_data, port_tx_data, r;
    logic [1:0]  ch_frame_start = 0, ch_field = 0, ch_hd = 0, ch_dec_valid = 0, ins_valid, gpi_ins_valid;
    logic [15:0] ch_dec_data = 0, ins_data;
    logic [7:0]  ch_rx_gpi = 0, contact_trigger_inputs = 0, gpi_ins_bits;
    logic [3:0]  port_rx_valid, port_tx_valid, port_speed;
    logic [21:0] ins_line, gpi_ins_line;
    int          error_cnt, cmp_count, cyc, n0, n1;
    int          rows[8][4] = '{'{0,1,0,1}, '{0,2,1,1}, '{0,3,2,1}, '{0,4,3,1}, '{1,1,0,1}, '{1,4,3,1},
                                '{1,2,0,0}, '{0,0,0,0}};
    always #2 pclk = ~pclk;
    cpr_router i_dut (.*);
    cpr_port_model i_gen (.*);
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(logic [11:0] a, logic [31:0] x, logic xe);
        apb(1'b0, a, 32'h0);
        chk("prdata", x, r);
        chk("pslverr", 32'(xe), 32'(e));
    endtask
    task automatic frame(logic [1:0] m);
        ch_frame_start <= m;
        @(posedge pclk);
        ch_frame_start <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic dec(int c, logic [7:0] b);
        ch_dec_valid[c] <= 1'b1;
        ch_dec_data[8*c+:8] <= b;
        @(posedge pclk);
        ch_dec_valid[c] <= 1'b0;
        ch_dec_data[8*c+:8] <= ~b;
    endtask
    function automatic logic [3:0] gexp(logic [3:0] c, logic o);
        gexp = o ? 4'h2 : 4'h0;
        for (int i = 0; i < 4; i++)
            gexp[3 - i] |= c[i] ^ (i % 2 == 0);
    endfunction
    always @(posedge pclk) if (++cyc == 20000) begin
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'h014, 32'h0015_0009, 1'b0);
        rdc(12'h01C, 32'h000D_000D, 1'b0);
        rdc(12'h004, 32'h0000_0007, 1'b0);
        rdc(12'h0FC, 32'h0, 1'b1);
        chk("ins_line", 32'h15, 32'(ins_line[10:0]));
        chk("gpi_off", 32'h0, 32'(gpi_ins_valid));
        foreach (rows[i]) begin
            apb(1'b1, 12'h010 + 12'(16 * rows[i][0]), 32'(rows[i][1]));
            frame(2'b11);
            i_gen.send(rows[i][2], 8'hA0 + 8'(i));
            #1 chk("ins_valid", 32'(rows[i][3]), 32'(ins_valid[rows[i][0]]));
            if (rows[i][3] == 1) chk("ins_data", 32'hA0 + i, 32'(ins_data[8*rows[i][0]+:8]));
            @(posedge pclk);
        end
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h020, 32'h0);
        apb(1'b1, 12'h000, 32'h9);
        frame(2'b11);
        dec(0, 8'h41);
        dec(1, 8'h42);
        repeat (4) @(posedge pclk);
        chk("tx_serial", 32'h0141, {16'h0, i_gen.got_q[0][0], i_gen.got_q[0][1]});
        chk("tx_eth1", 32'h0142, {16'h0, i_gen.got_q[1][0], i_gen.got_q[1][1]});
        apb(1'b1, 12'h000, 32'h5);
        apb(1'b1, 12'h004, 32'h103);
        chk("port_speed", 32'h3, 32'(port_speed));
        n0 = i_gen.got_q[0].size();
        n1 = i_gen.got_q[1].size();
        frame(2'b01);
        dec(0, 8'h77);
        repeat (4) @(posedge pclk);
        chk("raw_count", 32'(n0 + 1), 32'(i_gen.got_q[0].size()));
        chk("raw_byte", 32'h77, 32'(i_gen.got_q[0][n0]));
        chk("eth_tx_off", 32'(n1), 32'(i_gen.got_q[1].size()));
        for (int s = 1; s < 3; s++) begin
            apb(1'b1, 12'h010, 32'(s));
            frame(2'b01);
            i_gen.send(s - 1, 8'h88);
            #1 chk("rx_speed", 32'(s == 1), 32'(ins_valid[0]));
            @(posedge pclk);
        end
        n0 = i_gen.got_q[0].size();
        for (int x = 1; x < 7; x++) begin
            for (int f = 0; f < 2; f++) begin
                ch_field <= f ? 2'b11 : 2'b00;
                apb(1'b1, 12'h004, 32'(7 + 16 * x));
                dec(x / 4, 8'h60);
                #1 chk("bridge", 32'((x - 1) % 3 == 0 || (x - 1) % 3 == f + 1), 32'(ins_valid[1 - x / 4]));
                repeat (3) @(posedge pclk);
            end
        end
        chk("bridge_tx", 32'(n0), 32'(i_gen.got_q[0].size()));
        apb(1'b1, 12'h004, 32'h7);
        for (int o = 0; o < 2; o++) begin
            apb(1'b1, 12'h018, 32'h1B51 | 32'(o << 3));
            frame(2'b01);
            for (int k = 0; k < 3; k++) begin
                contact_trigger_inputs <= 8'(k * 7);
                ch_rx_gpi <= 8'h02;
                repeat (8) @(posedge pclk);
                #1 chk("gpi_bits", 32'(gexp(4'(k * 7), o[0])), 32'(gpi_ins_bits[3:0]));
                chk("gpi_on", 32'h1, 32'(gpi_ins_valid[0]));
                @(posedge pclk);
            end
        end
        apb(1'b1, 12'h018, 32'h0002_1B51);
        repeat (4) frame(2'b01);
        #1 chk("gpi_expired", 32'h0, 32'(gpi_ins_valid[0]));
        @(posedge pclk);
        for (int m = 1; m < 4; m++) begin
            for (int f = 0; f < 2; f++) begin
                ch_field <= f ? 2'b11 : 2'b00;
                apb(1'b1, 12'h018, 32'h0002_1B51 | 32'(m << 1));
                frame(2'b01);
                repeat (2) @(posedge pclk);
                #1 chk("perm", 32'(m == 3 || m == f + 1), 32'(gpi_ins_valid[0]));
                @(posedge pclk);
            end
        end
        ch_hd <= 2'b01;
        apb(1'b1, 12'h014, 32'h0064_00C8);
        apb(1'b1, 12'h01C, 32'h0190_012C);
        #1 chk("line_held", 32'h9, 32'(ins_line[10:0]));
        @(posedge pclk);
        frame(2'b01);
        #1 chk("cc_line_hd", 32'hC8, 32'(ins_line[10:0]));
        chk("gpi_line_hd", 32'h190, 32'(gpi_ins_line[10:0]));
        test_done();
    end
endmodule // tb_top
`default_nettype wire
